//--- verif/adc_rate_and_test_config_regs_bench.sv
`timescale 1ns/10ps
module adc_rate_and_test_config_regs_bench;
    import atc_pkg::*;
    localparam int BASE = 4;
    localparam int SLOW = 6;
    localparam int FAST = 5;
    logic        ref_clk;
    logic        sys_rst;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic        hresp;
    logic        clk_o;
    logic [31:0] hrdata;
    logic        clk_sel;
    logic        lead_off;
    logic        clk_oe;
    logic        mrb;
    logic        strobe;
    logic [2:0]  rate_act;
    logic        t_int;
    logic        t_amp;
    logic        t_sig;
    logic [31:0] rd;
    int          gap;
    int          n_mismatch;
    int          n_tests;

    atc_host_model atc_host_model_inst (
        .ref_clk(ref_clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata)
    );

    atc_regs #(.TEST_SLOW_LOG2(SLOW), .TEST_FAST_LOG2(FAST), .BASE_CYCLES(BASE)) atc_regs_inst (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .clock_source_select_pin(clk_sel), .bias_lead_off(lead_off),
        .clk_pin_o(clk_o), .clk_pin_oe(clk_oe), .multi_readback_mode(mrb), .conv_strobe(strobe),
        .rate_active(rate_act), .test_internal(t_int), .test_amp_double(t_amp), .test_signal(t_sig)
    );

    // Clock, 100 MHz
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // Compare and count
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Cycles between second and third event, skipping a part interval after a change
    task automatic wait_gap(input bit sel, input logic [2:0] code, output int g);
        int   n;
        int   k;
        logic last;
        logic ev;
        k = 0;
        g = 0;
        last = t_sig;
        for (n = 0; n < 4000 && k < 3; n++) begin
            @(posedge ref_clk);
            ev = sel ? (t_sig === 1'b1 && last === 1'b0) : (strobe === 1'b1 && rate_act === code);
            last = t_sig;
            if (k == 2) g++;
            if (ev) k++;
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] x;
        atc_host_model_inst.xfer(1'b1, a, d, x);
    endtask

    // Verdict and end of run
    task automatic conclude();
        $display("checks %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Watchdog, well beyond the few thousand cycles the tests need
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_mismatch++;
        conclude();
    end

    // Test sequence
    initial begin
        n_mismatch = 0;
        n_tests = 0;
        sys_rst = 1'b1;
        clk_sel = 1'b1;
        lead_off = 1'b0;
        repeat (20) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        atc_host_model_inst.xfer(1'b0, 32'h0000_0004, 32'h0000_0000, rd);
        chk("rate_reg", 32'h0000_0096, rd);
        chk("hresp", 32'(ATC_HRESP_OKAY), {31'h0, hresp});
        atc_host_model_inst.xfer(1'b0, 32'h0000_0008, 32'h0000_0000, rd);
        chk("test_reg", 32'h0000_00C0, rd);
        atc_host_model_inst.xfer(1'b0, 32'h0000_000C, 32'h0000_0000, rd);
        chk("bias_reg", 32'h0000_0060, rd);
        chk("mode", 32'h0000_0000, {31'h0, mrb});
        chk("clk_oe", 32'h0000_0000, {31'h0, clk_oe});
        chk("rate_act", 32'h0000_0006, {29'h0, rate_act});
        chk("t_int", 32'h0000_0000, {31'h0, t_int});
        chk("t_amp", 32'h0000_0000, {31'h0, t_amp});
        $display("reset test done");
        // Mode and clock output, reserved bits kept as required
        wr(32'h0000_0004, 32'h0000_00F6);
        atc_host_model_inst.xfer(1'b0, 32'h0000_0004, 32'h0000_0000, rd);
        chk("rate_reg", 32'h0000_00F6, rd);
        chk("mode", 32'h0000_0001, {31'h0, mrb});
        chk("clk_oe", 32'h0000_0001, {31'h0, clk_oe});
        clk_sel <= 1'b0;
        @(posedge ref_clk);
        chk("clk_oe", 32'h0000_0000, {31'h0, clk_oe});
        rd = {31'h0, clk_o};
        @(posedge ref_clk);
        chk("clk_pin_o", {31'h0, ~rd[0]}, {31'h0, clk_o});
        $display("mode test done");
        // Read-only status bit and unmapped address
        wr(32'h0000_000C, 32'h0000_0061);
        atc_host_model_inst.xfer(1'b0, 32'h0000_000C, 32'h0000_0000, rd);
        chk("bias_reg", 32'h0000_0060, rd);
        lead_off <= 1'b1;
        atc_host_model_inst.xfer(1'b0, 32'h0000_000C, 32'h0000_0000, rd);
        chk("bias_reg", 32'h0000_0061, rd);
        wr(32'h0000_0010, 32'h0000_00FF);
        atc_host_model_inst.xfer(1'b0, 32'h0000_0010, 32'h0000_0000, rd);
        chk("unmapped", 32'h0000_0000, rd);
        $display("status test done");
        // Every legal rate code; code 111 is never written
        for (int c = 0; c < 7; c++) begin
            wr(32'h0000_0004, 32'h0000_0090 | 32'(c));
            wait_gap(1'b0, 3'(c), gap);
            chk("conv_period", 32'(BASE << c), 32'(gap));
        end
        $display("rate test done");
        // Test source, amplitude and frequency codes; code 10 is never written
        wr(32'h0000_0008, 32'h0000_00D7);
        repeat (3) @(posedge ref_clk);
        chk("t_int", 32'h0000_0001, {31'h0, t_int});
        chk("t_amp", 32'h0000_0001, {31'h0, t_amp});
        chk("t_dc", 32'h0000_0001, {31'h0, t_sig});
        wr(32'h0000_0008, 32'h0000_00D0);
        wait_gap(1'b1, 3'h0, gap);
        chk("t_slow", 32'(1 << SLOW), 32'(gap));
        wr(32'h0000_0008, 32'h0000_00D1);
        wait_gap(1'b1, 3'h0, gap);
        chk("t_fast", 32'(1 << FAST), 32'(gap));
        wr(32'h0000_0008, 32'h0000_00C3);
        repeat (3) @(posedge ref_clk);
        chk("t_ext", 32'h0000_0000, {31'h0, t_sig});
        $display("test signal test done");
        conclude();
    end
endmodule

//--- verif/atc_host_model.sv
`timescale 1ns/10ps
// Host bus master; single whole-word transfers only
module atc_host_model
    import atc_pkg::*;
(
    input  wire logic        ref_clk, // Device clock
    input  wire logic        hready,  // Bus ready
    input  wire logic [31:0] hrdata,  // Read data
    output logic             hsel,    // Select
    output logic [31:0]      haddr,   // Address
    output logic [1:0]       htrans,  // Transfer type
    output logic             hwrite,  // Write
    output logic [2:0]       hsize,   // Size, always word
    output logic [31:0]      hwdata   // Write data
);
    // Idle bus at time zero
    initial begin
        hsel = 1'b1;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = ATC_HSIZE_WORD;
        hwdata = 32'h0000_0000;
    end

    // One transfer; entered just after a rising edge
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
        htrans <= ATC_HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= wr;
        do @(posedge ref_clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        // Reads carry no data, so the bus toggles rather than hold stale bits
        hwdata <= wr ? wd : ~hwdata;
        do @(posedge ref_clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
endmodule

//--- verilog/atc_pkg.sv
// What this block does
// - Rate register at index 0x01, resets 0x96
// - Bit 6 zero daisy-chain, one multi-readback
// - Bit 5 drives oscillator out when pin high
// - Rate field bits 2:0, resets 6
// - Codes 0..6 divide modulator clock 64..4096
// - Test register at index 0x02, resets 0xC0
// - Bit 4 selects internal test signal source
// - Bit 2 doubles internal test amplitude
// - Frequency field: 2^21, 2^20 pulses or dc
// - Bias register at index 0x03, resets 0x60
// - Bias register bit 0 is read-only status
package atc_pkg;

    // Register indexes; byte address is four times the index
    localparam logic [29:0] ATC_IDX_RATE = 30'h0000_0001;
    localparam logic [29:0] ATC_IDX_TEST = 30'h0000_0002;
    localparam logic [29:0] ATC_IDX_BIAS = 30'h0000_0003;

    // Reset values
    localparam logic [7:0] ATC_RATE_RST = 8'h96;
    localparam logic [7:0] ATC_TEST_RST = 8'hC0;
    localparam logic [7:0] ATC_BIAS_RST = 8'h60;

    // Field positions
    localparam int ATC_MODE_BIT   = 6;
    localparam int ATC_CLKEN_BIT  = 5;
    localparam int ATC_RATE_LSB   = 0;
    localparam int ATC_RATE_W     = 3;
    localparam int ATC_TSRC_BIT   = 4;
    localparam int ATC_TAMP_BIT   = 2;
    localparam int ATC_TFREQ_LSB  = 0;
    localparam int ATC_BSTAT_BIT  = 0;

    // Rate codes
    localparam logic [2:0] ATC_RATE_CODE_RST = 3'h6;
    localparam logic [2:0] ATC_RATE_CODE_MAX = 3'h6;
    localparam logic [2:0] ATC_RATE_CODE_RSV = 3'h7;

    // Clock ratios: modulator clock is device clock over two
    localparam int ATC_CLK_PERIOD_NS  = 10;
    localparam int ATC_MOD_DIV        = 2;
    localparam int ATC_RATE_BASE_DIV  = 64;
    localparam int ATC_BASE_CYCLES    = ATC_MOD_DIV * ATC_RATE_BASE_DIV;
    localparam int ATC_TEST_SLOW_LOG2 = 21;
    localparam int ATC_TEST_FAST_LOG2 = 20;

    // AHB-Lite encodings
    localparam logic [1:0] ATC_HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] ATC_HSIZE_WORD    = 3'h2;
    localparam logic       ATC_HRESP_OKAY    = 1'b0;
    localparam logic [31:0] ATC_RD_ZERO      = 32'h0000_0000;

    // Test frequency codes
    typedef enum logic [1:0] {
        ATC_TF_SLOW = 2'b00,
        ATC_TF_FAST = 2'b01,
        ATC_TF_RSVD = 2'b10,
        ATC_TF_DC   = 2'b11
    } atc_tfreq_t;

endpackage

//--- verilog/atc_rate_gen.sv
`timescale 1ns/10ps
// Conversion period timer; rate code is sampled only at a boundary
module atc_rate_gen
    import atc_pkg::*;
#(
    parameter int BASE_CYCLES = ATC_BASE_CYCLES,
    parameter int CNT_W       = 14
) (
    input  wire logic                  ref_clk,     // Device clock
    input  wire logic                  sys_rst,     // Async reset, high
    input  wire logic [ATC_RATE_W-1:0] rate_code,   // Programmed rate
    output logic                       conv_strobe, // Conversion boundary pulse
    output logic [ATC_RATE_W-1:0]      active_code  // Rate of running conversion
);

    logic [CNT_W-1:0]      cnt_r;
    logic [ATC_RATE_W-1:0] code_r;
    logic                  strobe_r;
    logic [ATC_RATE_W-1:0] eff_code;
    logic [CNT_W-1:0]      period_m1;
    logic                  last_cyc;

    // Reserved code falls back to the slowest rate
    assign eff_code    = (code_r == ATC_RATE_CODE_RSV) ? ATC_RATE_CODE_MAX : code_r;
    assign period_m1   = CNT_W'((BASE_CYCLES << eff_code) - 1);
    assign last_cyc    = (cnt_r == period_m1);
    assign conv_strobe = strobe_r;
    assign active_code = code_r;

    // Count cycles; pick up the new code only at a boundary
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_r    <= '0;
            code_r   <= ATC_RATE_CODE_RST;
            strobe_r <= 1'b0;
        end else if (last_cyc) begin
            cnt_r    <= '0;
            code_r   <= rate_code;
            strobe_r <= 1'b1;
        end else begin
            cnt_r    <= cnt_r + 1'b1;
            strobe_r <= 1'b0;
        end
    end

    cnt_range_a: assert property (@(posedge ref_clk) disable iff (sys_rst) cnt_r <= period_m1)
        else $error("rate counter past period");
    code_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !last_cyc |=> $stable(code_r))
        else $error("rate code changed mid conversion");

endmodule

//--- verilog/atc_regs.sv
`timescale 1ns/10ps
// Configuration bank: rate/chain, test signal, reference/bias
module atc_regs
    import atc_pkg::*;
#(
    parameter int TEST_SLOW_LOG2 = ATC_TEST_SLOW_LOG2,
    parameter int TEST_FAST_LOG2 = ATC_TEST_FAST_LOG2,
    parameter int BASE_CYCLES    = ATC_BASE_CYCLES
) (
    input  wire logic        ref_clk,                 // Device clock, 100 MHz
    input  wire logic        sys_rst,                 // Async reset, high
    input  wire logic        hsel,                    // AHB select
    input  wire logic [31:0] haddr,                   // AHB address
    input  wire logic [1:0]  htrans,                  // AHB transfer type
    input  wire logic        hwrite,                  // AHB write
    input  wire logic [2:0]  hsize,                   // AHB size
    input  wire logic [31:0] hwdata,                  // AHB write data
    input  wire logic        hready,                  // AHB bus ready
    output logic             hreadyout,               // Always ready
    output logic             hresp,                   // Always OKAY
    output logic [31:0]      hrdata,                  // Read data
    input  wire logic        clock_source_select_pin, // Internal clock chosen
    input  wire logic        bias_lead_off,           // Bias electrode open
    output logic             clk_pin_o,               // Oscillator out
    output logic             clk_pin_oe,              // Clock pin driven
    output logic             multi_readback_mode,     // 1 multi-readback, 0 daisy
    output logic             conv_strobe,             // Conversion boundary
    output logic [2:0]       rate_active,             // Rate of running conversion
    output logic             test_internal,           // Internal test source
    output logic             test_amp_double,         // Double amplitude
    output logic             test_signal              // Internal test waveform
);

    // Register storage and bus state
    logic [7:0]          rate_cfg_r;
    logic [7:0]          test_cfg_r;
    logic [7:1]          bias_cfg_r;
    logic                dp_wr_r;
    logic [29:0]         dp_idx_r;
    logic [31:0]         hrdata_r;
    logic                osc_r;
    logic                test_sig_r;
    logic [TEST_SLOW_LOG2-1:0] test_cnt_r;

    // Index match, used for write and read decode
    function automatic logic idx_hit(input logic [29:0] idx, input logic [29:0] target);
        idx_hit = (idx == target);
    endfunction

    // Address phase decode
    wire        ap_take  = hsel && hready && (htrans == ATC_HTRANS_NONSEQ);
    wire        ap_wr    = ap_take && hwrite && (hsize == ATC_HSIZE_WORD);
    wire        ap_rd    = ap_take && !hwrite;
    wire [29:0] ap_idx   = haddr[31:2];

    // Data phase write strobes
    wire wr_rate = dp_wr_r && idx_hit(dp_idx_r, ATC_IDX_RATE);
    wire wr_test = dp_wr_r && idx_hit(dp_idx_r, ATC_IDX_TEST);
    wire wr_bias = dp_wr_r && idx_hit(dp_idx_r, ATC_IDX_BIAS);

    // Current values, forwarding a write in its data phase
    wire [7:0] rate_now = wr_rate ? hwdata[7:0] : rate_cfg_r;
    wire [7:0] test_now = wr_test ? hwdata[7:0] : test_cfg_r;
    wire [7:1] bias_now = wr_bias ? hwdata[7:1] : bias_cfg_r;

    // Read mux; bias status bit comes live from the pin
    wire [7:0] rd_byte =
        idx_hit(ap_idx, ATC_IDX_RATE) ? rate_now :
        idx_hit(ap_idx, ATC_IDX_TEST) ? test_now :
        idx_hit(ap_idx, ATC_IDX_BIAS) ? {bias_now, bias_lead_off} : 8'h00;

    // Bus response: zero wait, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = ATC_HRESP_OKAY;
    assign hrdata    = hrdata_r;

    // Capture address phase
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            dp_wr_r  <= 1'b0;
            dp_idx_r <= '0;
            hrdata_r <= ATC_RD_ZERO;
        end else begin
            dp_wr_r  <= ap_wr;
            dp_idx_r <= ap_idx;
            hrdata_r <= ap_rd ? {24'h00_0000, rd_byte} : ATC_RD_ZERO;
        end
    end

    // Register writes; reserved bits are stored as written
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rate_cfg_r <= ATC_RATE_RST;
            test_cfg_r <= ATC_TEST_RST;
            bias_cfg_r <= ATC_BIAS_RST[7:1];
        end else begin
            rate_cfg_r <= rate_now;
            test_cfg_r <= test_now;
            bias_cfg_r <= bias_now;
        end
    end

    // Output mode selection
    assign multi_readback_mode = rate_cfg_r[ATC_MODE_BIT];

    // Oscillator onto the clock pin only with pin high and enable set
    assign clk_pin_oe = clock_source_select_pin && rate_cfg_r[ATC_CLKEN_BIT];
    assign clk_pin_o  = osc_r;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            osc_r <= 1'b0;
        end else begin
            osc_r <= !osc_r;
        end
    end

    // Conversion timer
    atc_rate_gen #(
        .BASE_CYCLES (BASE_CYCLES),
        .CNT_W       (14)
    ) atc_rate_gen_inst (
        .ref_clk     (ref_clk),
        .sys_rst     (sys_rst),
        .rate_code   (rate_cfg_r[ATC_RATE_LSB +: ATC_RATE_W]),
        .conv_strobe (conv_strobe),
        .active_code (rate_active)
    );

    // Test signal controls
    assign test_internal   = test_cfg_r[ATC_TSRC_BIT];
    assign test_amp_double = test_cfg_r[ATC_TAMP_BIT];
    assign test_signal     = test_sig_r;

    wire [1:0] tfreq = test_cfg_r[ATC_TFREQ_LSB +: 2];

    // Square wave with period 2^21 or 2^20, or dc level
    wire test_sig_nxt =
        (tfreq == ATC_TF_SLOW) ? test_cnt_r[TEST_SLOW_LOG2-1] :
        (tfreq == ATC_TF_FAST) ? test_cnt_r[TEST_FAST_LOG2-1] :
        (tfreq == ATC_TF_DC)   ? 1'b1 : 1'b0;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            test_cnt_r <= '0;
            test_sig_r <= 1'b0;
        end else begin
            test_cnt_r <= test_cnt_r + 1'b1;
            test_sig_r <= test_internal && test_sig_nxt;
        end
    end

    // Helper: cycles between conversion strobes and the rate in force
    logic [15:0] gap_r;
    logic [2:0]  per_code_r;
    logic        seen_r;
    wire  [2:0]  per_eff = (per_code_r == ATC_RATE_CODE_RSV) ? ATC_RATE_CODE_MAX : per_code_r;
    wire  [15:0] per_m1  = 16'((BASE_CYCLES << per_eff) - 1);

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            gap_r      <= '0;
            per_code_r <= ATC_RATE_CODE_RST;
            seen_r     <= 1'b0;
        end else if (conv_strobe) begin
            gap_r      <= '0;
            per_code_r <= rate_active;
            seen_r     <= 1'b1;
        end else begin
            gap_r      <= gap_r + 1'b1;
        end
    end

    rate_write_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        wr_rate |=> rate_cfg_r == $past(hwdata[7:0]))
        else $error("rate register did not take write");

    mode_follow_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        wr_rate |=> multi_readback_mode == $past(hwdata[ATC_MODE_BIT]))
        else $error("output mode does not follow write");

    clk_gate_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !clock_source_select_pin || !rate_cfg_r[ATC_CLKEN_BIT] |-> !clk_pin_oe)
        else $error("clock pin driven while disabled");

    rate_period_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        conv_strobe && seen_r |-> gap_r == per_m1)
        else $error("conversion period wrong for rate");

    rate_apply_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        conv_strobe |-> rate_active == $past(rate_cfg_r[ATC_RATE_LSB +: ATC_RATE_W]))
        else $error("new rate not applied at boundary");

    test_write_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        wr_test |=> test_internal == $past(hwdata[ATC_TSRC_BIT])
            && test_amp_double == $past(hwdata[ATC_TAMP_BIT]))
        else $error("test controls do not follow write");

    test_dc_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        test_internal && tfreq == ATC_TF_DC ##1 test_internal && tfreq == ATC_TF_DC |-> test_signal)
        else $error("dc test level missing");

    bias_write_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        wr_bias |=> bias_cfg_r == $past(hwdata[7:1]))
        else $error("bias register did not take write");

    bias_status_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        ap_rd && idx_hit(ap_idx, ATC_IDX_BIAS) |=> hrdata[ATC_BSTAT_BIT] == $past(bias_lead_off))
        else $error("bias status read wrong");

    test_amp_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !wr_test |=> $stable(test_amp_double))
        else $error("amplitude select changed without write");

    // Rate register holds between writes
    rate_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !wr_rate |=> $stable(rate_cfg_r))
        else $error("rate register changed without write");

    // Output mode holds between writes
    mode_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !wr_rate |=> $stable(multi_readback_mode))
        else $error("output mode changed without write");

    // Bias register holds between writes
    bias_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !wr_bias |=> $stable(bias_cfg_r))
        else $error("bias register changed without write");

    // Pin high and enable set must drive the clock pin
    clk_on_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        clock_source_select_pin && rate_cfg_r[ATC_CLKEN_BIT] |-> clk_pin_oe)
        else $error("clock pin not driven while enabled");

    // Oscillator stand-in toggles every cycle once out of reset
    osc_toggle_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !$past(sys_rst) |-> clk_pin_o != $past(clk_pin_o))
        else $error("oscillator output stuck");

    // External source keeps the internal waveform low
    test_ext_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !$past(test_internal) |-> !test_signal)
        else $error("test waveform active with external source");

    // Read data is zero outside a read data phase
    rd_idle_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !ap_rd |=> hrdata == ATC_RD_ZERO)
        else $error("read data not zero when idle");

    // Registers are eight bits; upper read bits are zero
    rd_upper_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        hrdata[31:8] == 24'h00_0000)
        else $error("upper read data bits set");

    // Unmapped reads return zero
    rd_unmap_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        ap_rd && !idx_hit(ap_idx, ATC_IDX_RATE) && !idx_hit(ap_idx, ATC_IDX_TEST)
            && !idx_hit(ap_idx, ATC_IDX_BIAS) |=> hrdata == ATC_RD_ZERO)
        else $error("unmapped read not zero");

    // Non-word writes are dropped
    wr_size_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        ap_take && hwrite && hsize != ATC_HSIZE_WORD |=> !dp_wr_r)
        else $error("non-word write accepted");

    // Unmapped writes leave every register unchanged
    wr_unmap_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        dp_wr_r && !wr_rate && !wr_test && !wr_bias
            |=> $stable(rate_cfg_r) && $stable(test_cfg_r) && $stable(bias_cfg_r))
        else $error("unmapped write changed a register");

    // Conversion boundary is a single-cycle pulse
    strobe_pulse_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        conv_strobe |=> !conv_strobe)
        else $error("conversion strobe longer than a cycle");

    // Rate in force changes only at a boundary
    rate_pick_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !conv_strobe |-> $stable(rate_active))
        else $error("rate in force changed between boundaries");

    // Read of rate register returns stored value
    rate_read_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        ap_rd && idx_hit(ap_idx, ATC_IDX_RATE) && !wr_rate |=> hrdata[7:0] == $past(rate_cfg_r))
        else $error("rate register read wrong");

    // Read of test register returns stored value
    test_read_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        ap_rd && idx_hit(ap_idx, ATC_IDX_TEST) && !wr_test |=> hrdata[7:0] == $past(test_cfg_r))
        else $error("test register read wrong");

    // Read of bias register returns stored writable bits
    bias_read_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        ap_rd && idx_hit(ap_idx, ATC_IDX_BIAS) && !wr_bias |=> hrdata[7:1] == $past(bias_cfg_r))
        else $error("bias register read wrong");

    // Read right behind a write sees the new value
    wr_fwd_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        ap_rd && wr_rate && idx_hit(ap_idx, ATC_IDX_RATE) |=> hrdata[7:0] == $past(hwdata[7:0]))
        else $error("write not forwarded to read");

    cov_rate_wr: cover property (@(posedge ref_clk) disable iff (sys_rst) wr_rate);
    cov_bias_rd: cover property (@(posedge ref_clk) disable iff (sys_rst)
        ap_rd && idx_hit(ap_idx, ATC_IDX_BIAS));
    cov_fast_conv: cover property (@(posedge ref_clk) disable iff (sys_rst)
        conv_strobe && rate_active == 3'h0);
    cov_clk_out: cover property (@(posedge ref_clk) disable iff (sys_rst) clk_pin_oe);
    cov_dc_test: cover property (@(posedge ref_clk) disable iff (sys_rst)
        test_internal && tfreq == ATC_TF_DC);

endmodule
